// File: lcd_host.sv
`timescale 1ns/1ps
module lcd_host
  import lcd_host_pkg::*;
(
  input wire logic I_SYS_CLK, // System clock, 50 MHz.
  input wire logic I_RST_N, // Synchronous reset, active low.
  input wire logic [3:0] I_ADDR, // Register byte address.
  input wire logic [15:0] I_WDATA, // Register write data.
  input wire logic I_WR, // Write strobe.
  input wire logic I_RD, // Read strobe.
  output logic [15:0] O_RDATA, // Read data, valid the cycle after I_RD.
  output logic O_E, // Parallel strobe.
  output logic O_RS, // Parallel register select.
  output logic O_RW, // Parallel direction, high for read.
  input wire logic [7:0] I_DB, // Parallel data lines, input side.
  output logic [7:0] O_DB, // Parallel data lines, output value.
  output logic [7:0] O_DB_OE_N, // Parallel data lines, low drives.
  input wire logic I_SCL, // Serial clock line level.
  output logic O_SCL_O, // Serial clock drive value, always low.
  output logic O_SCL_OE_N, // Serial clock pull-down, low pulls.
  input wire logic I_SDA, // Serial data line level.
  output logic O_SDA_O, // Serial data drive value, always low.
  output logic O_SDA_OE_N // Serial data pull-down, low pulls.
);
  typedef enum logic [2:0] {ST_IDLE, ST_P_SET, ST_P_HIGH, ST_P_HOLD, ST_I_WAIT, ST_I_START, ST_I_BIT, ST_I_STOP}
    state_t;

  state_t state;
  logic [1:0] cfg;
  logic [7:0] cmd_byte;
  logic cmd_rs;
  logic cmd_rd;
  logic cmd_i2c;
  logic ext_page;
  logic nack_err;
  logic refused;
  logic [7:0] rx_byte;
  logic [7:0] shreg;
  logic [7:0] tmr;
  logic [1:0] q;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic nib;
  logic sda_s1, sda_s2, scl_s1, scl_s2;
  logic [7:0] db_s1, db_s2;
  logic start_req, bad_cmd, go, tick, rx_phase, last_byte, nack_seen, done_rx;
  logic [7:0] tx_byte;

  // Pins from the far side pass two flops before anything looks at them.
  always_ff @(posedge I_SYS_CLK) begin
    sda_s1 <= I_SDA;
    sda_s2 <= sda_s1;
    scl_s1 <= I_SCL;
    scl_s2 <= scl_s1;
    db_s1 <= I_DB;
    db_s2 <= db_s1;
  end

  assign start_req = I_WR && (I_ADDR == ADDR_CMD) && (state == ST_IDLE);
  // The forbidden stage code is refused here rather than passed to the device.
  assign bad_cmd = !I_WDATA[CMD_RS_BIT] && !I_WDATA[CMD_READ_BIT] && (I_WDATA[7:2] == MULT_CFG_OP)
                   && (I_WDATA[1:0] == MULT_FORBIDDEN);
  assign go = start_req && !bad_cmd;
  assign tick = (tmr == 8'h00);
  assign rx_phase = cmd_rd && (byte_idx == 2'h1);
  assign last_byte = cmd_rd ? (byte_idx == 2'h1) : (byte_idx == 2'h2);
  assign nack_seen = (state == ST_I_BIT) && tick && (q == 2'h2) && (bit_cnt == 4'h8) && !rx_phase && sda_s2;
  assign done_rx = ((state == ST_I_BIT) && tick && (q == 2'h3) && (bit_cnt == 4'h7) && rx_phase)
                   || ((state == ST_P_HIGH) && tick && cmd_rd && (!cfg[CFG_NIBBLE_BIT] || nib));

  // The address byte always leads, so the device can judge selection by it alone.
  always_comb begin
    if (byte_idx == 2'h0) begin
      tx_byte = {I2C_ADDR_HI, cfg[CFG_STRAP_BIT], cmd_rd};
    end else if (byte_idx == 2'h1) begin
      tx_byte = cmd_rs ? I2C_CTRL_DATA : I2C_CTRL_INSTR;
    end else begin
      tx_byte = cmd_byte;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      cfg <= 2'h0;
    end else if (I_WR && (I_ADDR == ADDR_CFG)) begin
      cfg <= I_WDATA[1:0];
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      cmd_byte <= 8'h00;
      cmd_rs <= 1'b0;
      cmd_rd <= 1'b0;
      cmd_i2c <= 1'b0;
      ext_page <= 1'b0;
    end else if (go) begin
      cmd_byte <= I_WDATA[7:0];
      cmd_rs <= I_WDATA[CMD_RS_BIT];
      cmd_rd <= I_WDATA[CMD_READ_BIT];
      cmd_i2c <= I_WDATA[CMD_I2C_BIT];
      // Track which instruction page the device is in after each function set.
      if (!I_WDATA[CMD_RS_BIT] && !I_WDATA[CMD_READ_BIT] && ((I_WDATA[7:0] & FUNC_SET_MASK) == FUNC_SET_VAL)) begin
        ext_page <= I_WDATA[FUNC_PAGE_BIT];
      end
    end
  end

  // Error flags: a new event in the clearing cycle wins over the clear.
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      nack_err <= 1'b0;
      refused <= 1'b0;
    end else begin
      if (I_WR && (I_ADDR == ADDR_STAT)) begin
        nack_err <= 1'b0;
        refused <= 1'b0;
      end
      if (nack_seen) begin
        nack_err <= 1'b1;
      end
      if (start_req && bad_cmd) begin
        refused <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_RDATA <= 16'h0000;
    end else if (I_RD) begin
      if (I_ADDR == ADDR_CMD) begin
        O_RDATA <= {5'h00, cmd_i2c, cmd_rd, cmd_rs, cmd_byte};
      end else if (I_ADDR == ADDR_CFG) begin
        O_RDATA <= {14'h0000, cfg};
      end else if (I_ADDR == ADDR_STAT) begin
        O_RDATA <= {rx_byte, 4'h0, ext_page, refused, nack_err, state != ST_IDLE};
      end else begin
        O_RDATA <= 16'h0000;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      tmr <= 8'h00;
    end else if (go) begin
      tmr <= (I_WDATA[CMD_I2C_BIT] ? I2C_QUARTER_CYC : E_PHASE_CYC) - 8'h01;
    end else if (state == ST_IDLE || tick) begin
      tmr <= (cmd_i2c ? I2C_QUARTER_CYC : E_PHASE_CYC) - 8'h01;
    end else begin
      tmr <= tmr - 8'h01;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      rx_byte <= 8'h00;
    end else if (done_rx) begin
      if (cmd_i2c) begin
        // All eight bits were shifted in at the last sample point, so no further shift is due.
        rx_byte <= shreg;
      end else if (cfg[CFG_NIBBLE_BIT]) begin
        rx_byte <= {shreg[7:4], db_s2[7:4]};
      end else begin
        rx_byte <= db_s2;
      end
    end
  end

  // Link sequencing and pin drive.
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      state <= ST_IDLE;
      O_E <= 1'b0;
      O_RS <= 1'b0;
      O_RW <= 1'b0;
      O_DB <= 8'h00;
      O_DB_OE_N <= 8'hFF;
      O_SCL_O <= 1'b0;
      O_SCL_OE_N <= 1'b1;
      O_SDA_O <= 1'b0;
      O_SDA_OE_N <= 1'b1;
      q <= 2'h0;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      nib <= 1'b0;
      shreg <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          q <= 2'h0;
          bit_cnt <= 4'h0;
          byte_idx <= 2'h0;
          nib <= 1'b0;
          if (go) begin
            state <= I_WDATA[CMD_I2C_BIT] ? ST_I_WAIT : ST_P_SET;
          end
        end
        ST_P_SET: begin
          O_RS <= cmd_rs;
          O_RW <= cmd_rd;
          if (cmd_rd) begin
            O_DB_OE_N <= 8'hFF;
          end else if (cfg[CFG_NIBBLE_BIT]) begin
            O_DB <= {nib ? cmd_byte[3:0] : cmd_byte[7:4], 4'h0};
            O_DB_OE_N <= 8'h0F;
          end else begin
            O_DB <= cmd_byte;
            O_DB_OE_N <= 8'h00;
          end
          if (tick) begin
            O_E <= 1'b1;
            state <= ST_P_HIGH;
          end
        end
        ST_P_HIGH: begin
          if (tick) begin
            O_E <= 1'b0;
            shreg <= {db_s2[7:4], shreg[3:0]};
            state <= ST_P_HOLD;
          end
        end
        ST_P_HOLD: begin
          if (tick) begin
            if (cfg[CFG_NIBBLE_BIT] && !nib) begin
              nib <= 1'b1;
              state <= ST_P_SET;
            end else begin
              O_DB_OE_N <= 8'hFF;
              O_RW <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        ST_I_WAIT: begin
          if (sda_s2 && scl_s2) begin
            state <= ST_I_START;
          end
        end
        ST_I_START: begin
          if (tick) begin
            q <= q + 2'h1;
            if (q == 2'h0) begin
              O_SDA_OE_N <= 1'b0;
            end else begin
              O_SCL_OE_N <= 1'b0;
              q <= 2'h0;
              shreg <= tx_byte;
              state <= ST_I_BIT;
            end
          end
        end
        ST_I_BIT: begin
          if (tick) begin
            q <= q + 2'h1;
            if (q == 2'h0) begin
              if (bit_cnt == 4'h8) begin
                // Released on the ack slot: the slave acks writes, and the single read
                // byte is the last, so the master leaves it unacknowledged.
                O_SDA_OE_N <= 1'b1;
              end else begin
                O_SDA_OE_N <= rx_phase ? 1'b1 : shreg[7];
              end
            end else if (q == 2'h1) begin
              O_SCL_OE_N <= 1'b1;
            end else if (q == 2'h2) begin
              if (bit_cnt != 4'h8) begin
                shreg <= {shreg[6:0], sda_s2};
              end
            end else begin
              O_SCL_OE_N <= 1'b0;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h8) begin
                bit_cnt <= 4'h0;
                if (last_byte || nack_err) begin
                  state <= ST_I_STOP;
                end else begin
                  byte_idx <= byte_idx + 2'h1;
                  shreg <= (byte_idx == 2'h0) ? (cmd_rs ? I2C_CTRL_DATA : I2C_CTRL_INSTR) : cmd_byte;
                end
              end
            end
          end
        end
        ST_I_STOP: begin
          if (tick) begin
            q <= q + 2'h1;
            if (q == 2'h0) begin
              O_SDA_OE_N <= 1'b0;
            end else if (q == 2'h1) begin
              O_SCL_OE_N <= 1'b1;
            end else if (q == 2'h2) begin
              O_SDA_OE_N <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// File: lcd_host_pkg.sv
// How it works
// - Stage codes 00, 01, 10 give one to three stages; 11 never sent.
// - Voltage factors need the extended page, entered and left by function set.
// - In byte mode one strobe moves a whole byte on all eight lines.
// - In nibble mode two strobes move a byte, high nibble first.
// - In nibble mode a busy-flag read also takes two strobes.
// - In nibble mode the lower four data lines are left undriven.
// - The first byte after START is always address plus direction.
// - The master leaves the last read byte unacknowledged, then issues STOP.
// - The acknowledger holds data low through the acknowledge clock high time.
// - A serial transfer starts only with both lines idle high.
package lcd_host_pkg;
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam int CMD_RS_BIT = 8;
  localparam int CMD_READ_BIT = 9;
  localparam int CMD_I2C_BIT = 10;
  localparam int CFG_NIBBLE_BIT = 0;
  localparam int CFG_STRAP_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_PAGE_BIT = 3;
  localparam logic [5:0] MULT_CFG_OP = 6'h10;
  localparam logic [1:0] MULT_FORBIDDEN = 2'h3;
  localparam logic [7:0] FUNC_SET_MASK = 8'hE0;
  localparam logic [7:0] FUNC_SET_VAL = 8'h20;
  localparam int FUNC_PAGE_BIT = 0;
  localparam logic [5:0] I2C_ADDR_HI = 6'h1D;
  localparam logic [7:0] I2C_CTRL_INSTR = 8'h00;
  localparam logic [7:0] I2C_CTRL_DATA = 8'h40;
  localparam int SYS_CLK_MHZ = 50;
  localparam int E_PHASE_NS = 500;
  localparam int I2C_QUARTER_NS = 2500;
  localparam logic [7:0] E_PHASE_CYC = 8'((E_PHASE_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] I2C_QUARTER_CYC = 8'((I2C_QUARTER_NS * SYS_CLK_MHZ + 999) / 1000);
endpackage

// File: lcd_host_monitor.sv
`timescale 1ns/1ps
module lcd_host_monitor
  import lcd_host_pkg::*;
(
  input wire logic I_SYS_CLK, // Clock.
  input wire logic I_RST_N, // Reset.
  input wire logic [3:0] I_ADDR, // Address.
  input wire logic [15:0] I_WDATA, // Data.
  input wire logic I_WR, // Write.
  input wire logic O_E, // Strobe.
  input wire logic O_RS, // Select.
  input wire logic O_RW, // Direction.
  input wire logic [7:0] O_DB, // Lines.
  input wire logic [7:0] O_DB_OE_N, // Enables.
  input wire logic I_SCL, // Clock line.
  input wire logic I_SDA, // Data line.
  input wire logic O_SCL_OE_N, // Clock pull.
  input wire logic O_SDA_OE_N // Data pull.
);
  logic nib;
  logic [7:0] hush;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) nib <= 1'b0;
    else if (I_WR && I_ADDR == ADDR_CFG) nib <= I_WDATA[CFG_NIBBLE_BIT];
  end
  // The window stays open for 200 cycles or until the next command, since a legal strobe may follow that command at once.
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) hush <= 8'h00;
    else if (I_WR && I_ADDR == ADDR_CMD && I_WDATA[9:0] == {2'h0, MULT_CFG_OP, MULT_FORBIDDEN}) hush <= 8'hC8;
    else if (I_WR && I_ADDR == ADDR_CMD) hush <= 8'h00;
    else if (hush != 8'h00) hush <= hush - 8'h01;
  end
  sequence e_up; $rose(O_E); endsequence
  sequence e_down; $fell(O_E); endsequence
  nib_lines_a: assert property (nib |-> O_DB_OE_N[3:0] == 4'hF)
    else $error("lower lines driven");
  rd_release_a: assert property (O_RW |-> O_DB_OE_N == 8'hFF)
    else $error("lines driven in read");
  wr_drive_a: assert property (O_E && !O_RW |-> O_DB_OE_N[7:4] == 4'h0)
    else $error("upper lines idle in write");
  strobe_setup_a: assert property (e_up |-> $stable({O_RS, O_RW, O_DB}))
    else $error("setup broken");
  strobe_hold_a: assert property (e_down |-> $stable({O_RS, O_RW, O_DB}))
    else $error("hold broken");
  no_forbidden_a: assert property (hush != 8'h00 |-> !O_E && O_SDA_OE_N)
    else $error("code 11 sent");
  start_idle_a: assert property ($fell(O_SDA_OE_N) && O_SCL_OE_N |-> $past(I_SDA) && $past(I_SCL))
    else $error("start on busy bus");
  sda_hold_a: assert property ($rose(O_SCL_OE_N) |=> $stable(O_SDA_OE_N)[*8])
    else $error("data moved in clock high");
endmodule
bind lcd_host lcd_host_monitor mon (.I_SYS_CLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .O_E, .O_RS, .O_RW, .O_DB,
  .O_DB_OE_N, .I_SCL, .I_SDA, .O_SCL_OE_N, .O_SDA_OE_N);

// File: lcd_dev_model.sv
`timescale 1ns/1ps
module lcd_dev_model #(
  parameter logic STRAP = 1'b1
) (
  input wire logic i_e, // Strobe.
  input wire logic i_rs, // Select.
  input wire logic i_rw, // Direction.
  input wire logic i_nib, // Nibble mode.
  input wire logic [7:0] i_db, // Lines.
  output logic [7:0] o_db, // Read drive.
  input wire logic i_scl, // Clock line.
  input wire logic i_sda, // Data line.
  output logic o_sda_oe_n // Low pulls data.
);
  logic [8:0] rx_q[$];
  logic [7:0] rd_val = 8'h00, hi, sh, ctl;
  logic [1:0] tc = 2'h0, mult;
  logic [5:0] va, vb;
  logic ph = 1'b0, page = 1'b0, sel = 1'b0, rd, first, ak;
  int bitc, nb;
  logic up = 1'b0, im = 1'b0;
  logic gen_on;
  initial o_sda_oe_n = 1'b1;
  // The clock line is only ever read here, so the host never sees it held low.
  assign gen_on = (im ? vb : va) != 6'h00;
  // Display-off and power-down are not modelled; either would also force the generator off.
  assign o_db = i_nib ? {ph ? rd_val[3:0] : rd_val[7:4], 4'hF} : rd_val;
  task automatic take(input logic s, input logic [7:0] b);
    rx_q.push_back({s, b});
    if (!s && b[7:2] == 6'h04) tc = b[1:0];
    if (!s && b[7:2] == 6'h10) mult = b[1:0];
    if (!s && b[7] && page && b[6]) vb = b[5:0];
    if (!s && b[7] && page && !b[6]) va = b[5:0];
    if (!s && b[7:5] == 3'h1) page = b[0];
    if (!s && b[7:3] == 5'h01) im = b[2];
  endtask
  always @(posedge i_e) up = 1'b1;
  // The step of the strobe from unknown to low at reset is no transfer, so only falls after a rise count.
  always @(negedge i_e) if (up) begin
    if (i_nib && !ph) hi = i_db[7:4];
    else if (!i_rw) take(i_rs, i_nib ? {hi, i_db[7:4]} : i_db);
    if (i_nib) ph = !ph;
  end
  always @(negedge i_sda) begin
    if (i_scl) first = 1'b1;
    if (i_scl) bitc = 0;
    if (i_scl) nb = 0;
  end
  always @(posedge i_sda) if (i_scl) sel = 1'b0;
  always @(posedge i_scl) begin
    sh = {sh[6:0], i_sda};
    bitc++;
  end
  always @(negedge i_scl) begin
    ak = 1'b0;
    if (bitc == 8 && first) begin
      sel = sh[7:1] == {6'b011101, STRAP};
      rd = sh[0];
      first = 1'b0;
      ak = sel;
    end else if (bitc == 8 && sel) begin
      if (!rd && nb > 0) take(ctl[6], sh);
      else ctl = sh;
      nb++;
      ak = !rd;
    end
    if (bitc == 9) bitc = 0;
    // Only one byte is served per read; the line is then let go for the NACK and STOP.
    o_sda_oe_n = !(ak || sel && rd && nb == 0 && bitc < 8 && !rd_val[7 - bitc]);
  end
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import lcd_host_pkg::*;
  logic I_SYS_CLK = 0, I_RST_N = 0, I_WR = 0, I_RD = 0, junk = 0;
  logic [3:0] I_ADDR = 0;
  logic [15:0] I_WDATA = 0, O_RDATA, d;
  logic [7:0] O_DB, O_DB_OE_N, db, dd, b;
  logic O_E, O_RS, O_RW, O_SCL_OE_N, O_SDA_OE_N, O_SCL_O, O_SDA_O, dsda, sda, scl;
  logic [5:0] ea, eb;
  logic [8:0] exp_q[$];
  int num_errors = 0, n_checks = 0, i, j, k;
  // A pulled line shows the drive value; a released one floats up to its pull-up.
  assign sda = (O_SDA_OE_N | O_SDA_O) & dsda;
  assign scl = O_SCL_OE_N | O_SCL_O;
  // Undriven lines toggle, save the lower four held high in nibble mode, so a stale value cannot pass for a real one.
  assign db = (O_DB & ~O_DB_OE_N) | (O_DB_OE_N & (O_E && O_RW ? dd : {{4{junk}}, i == 1 ? 4'hF : {4{~junk}}}));
  always @(posedge I_SYS_CLK) junk <= !junk;
  initial forever #10 I_SYS_CLK = !I_SYS_CLK;
  lcd_host uut (.I_SYS_CLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_E, .O_RS, .O_RW, .I_DB(db),
    .O_DB, .O_DB_OE_N, .I_SCL(scl), .O_SCL_O, .O_SCL_OE_N, .I_SDA(sda), .O_SDA_O, .O_SDA_OE_N);
  lcd_dev_model dev (.i_e(O_E), .i_rs(O_RS), .i_rw(O_RW), .i_nib(i == 1), .i_db(db), .o_db(dd),
    .i_scl(scl), .i_sda(sda), .o_sda_oe_n(dsda));
  task automatic test_done();
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] v);
    @(posedge I_SYS_CLK);
    {I_WR, I_RD, I_ADDR, I_WDATA} <= {w, !w, a, v};
    @(posedge I_SYS_CLK);
    {I_WR, I_RD} <= 2'b00;
    #1 d = O_RDATA;
  endtask
  task automatic idle();
    for (k = 0; k < 10000; k++) begin
      acc(0, ADDR_STAT, 0);
      if (d[STAT_BUSY_BIT] === 1'b0) break;
    end
    if (k == 10000) begin
      num_errors++;
      test_done();
    end
  endtask
  task automatic send(input logic [9:0] c, input logic ser);
    acc(1, ADDR_CMD, {5'h0, ser, c});
    idle();
    // A refused code gets time to show on the pins before the next command may legally drive them.
    if (c == {2'h0, MULT_CFG_OP, MULT_FORBIDDEN}) repeat (60) @(posedge I_SYS_CLK);
    else exp_q.push_back(c[8:0]);
    chk("refused", 16'(c == {2'h0, MULT_CFG_OP, MULT_FORBIDDEN}), 16'(d[STAT_REFUSED_BIT]));
    chk("count", 16'(exp_q.size()), 16'(dev.rx_q.size()));
    while (exp_q.size() && dev.rx_q.size()) chk("byte", 16'(exp_q.pop_front()), 16'(dev.rx_q.pop_front()));
    acc(1, ADDR_STAT, 0);
  endtask
  initial begin
    void'($urandom(30604));
    repeat (2) @(posedge I_SYS_CLK);
    I_RST_N <= 1;
    for (i = 0; i < 2; i++) begin
      acc(1, ADDR_CFG, 16'(i));
      for (j = 0; j < 8; j++) send({2'h0, j[2] ? 6'h10 : 6'h04, j[1:0]}, 0);
      chk("coeff", 16'h000E, {12'h000, dev.tc, dev.mult});
      send(10'h021, 0);
      chk("page", 16'h0001, 16'(d[STAT_PAGE_BIT]));
      for (j = 0; j < 2; j++) begin
        b = $urandom;
        if (j[0]) eb = b[5:0];
        else ea = b[5:0];
        send({3'h1, j[0], b[5:0]}, 0);
        if (i + j > 0) chk("factor", {4'h0, ea, eb}, {4'h0, dev.va, dev.vb});
      end
      send(10'h020, 0);
      chk("page off", 16'h0000, 16'(d[STAT_PAGE_BIT]));
      chk("generator", 16'(ea != 6'h00), 16'(dev.gen_on));
      b = $urandom;
      dev.rd_val = b;
      acc(1, ADDR_CMD, 16'h0200);
      idle();
      chk("read", 16'(b), 16'(d[15:8]));
    end
    acc(1, ADDR_CFG, 16'h0002);
    b = $urandom;
    send({2'h1, b}, 1);
    b = $urandom;
    dev.rd_val = b;
    acc(1, ADDR_CMD, 16'h0600);
    idle();
    chk("serial read", 16'(b), 16'(d[15:8]));
    acc(1, ADDR_CFG, 0);
    acc(1, ADDR_CMD, 16'h0404);
    idle();
    chk("nack", 1, 16'(d[STAT_NACK_BIT]));
    acc(0, 4'hC, 0);
    chk("unmapped", 0, d);
    test_done();
  end
endmodule
